/* hw/nvmcf_consts.svh */
`ifndef NVMCF_CONSTS_SVH
`define NVMCF_CONSTS_SVH
// command codes
`define NVMCF_CMD_CRC 8'hF0
`define NVMCF_CMD_INJ 8'hF1
// crc generator and seed
`define NVMCF_CRC_POLY 16'h8005
`define NVMCF_CRC_SEED 16'h0000
// injection register field positions
`define NVMCF_BIT_FAULT_HOLD 15
`define NVMCF_BIT_OTF 14
`define NVMCF_BIT_OCF 12
`define NVMCF_BIT_LOCKOUT 11
`define NVMCF_BIT_VINOVF 10
`define NVMCF_BIT_UVF 9
`define NVMCF_BIT_OVF 8
`define NVMCF_BIT_WARN_HOLD 7
`define NVMCF_BIT_OCW 4
`define NVMCF_BIT_VINUVW 3
`define NVMCF_BIT_UVW 1
`define NVMCF_BIT_OVW 0
// injection register reset and usable bits
`define NVMCF_INJ_RESET 16'h0000
`define NVMCF_FAULT_MASK 16'h5F00
`define NVMCF_WARN_MASK 16'h001B
`define NVMCF_HOLD_MASK 16'h8080
`endif

/* hw/nvmcf_pkg.sv */
package nvmcf_pkg;
   typedef enum logic [1:0] {
      NVMCF_IDLE = 2'b00,
      NVMCF_REQ = 2'b01,
      NVMCF_RUN = 2'b10
   } nvmcf_state_t;
endpackage : nvmcf_pkg

/* hw/nvmcf_settings_rom.sv */
`timescale 1ns/10ps
`default_nettype none
// settings storage view: registered read port onto the stored settings words
module nvmcf_settings_rom
   import nvmcf_pkg::*;
#(
   parameter int WORDS = 16,
   parameter int AW = 4
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [AW-1:0] readAddr,
   input wire logic [WORDS*16-1:0] settingsImage,
   output logic [15:0] readData
);
   // refuse a word count the address cannot reach
   if (WORDS < 1 || WORDS > (1 << AW))
   begin : g_bad_words
      $error("settings word count does not fit the address width");
   end

   // registered read keeps the crc engine off a long mux path
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         readData <= 16'h0000;
      end
      else
      begin
         readData <= settingsImage[readAddr*16 +: 16];
      end
   end
endmodule : nvmcf_settings_rom
`default_nettype wire

/* hw/nvm_crc_and_fault_injection.sv */
`timescale 1ns/10ps
`default_nettype none
`include "nvmcf_consts.svh"

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - checksum is a 16-bit CRC, generator 0x8005, over stored settings.
// - checksum recomputed after boot and after each store or restore that arrives while no walk is running.
// - checksum is read-only 16-bit word at F0h; writes refused.
// - injection register at F1h accepts word writes and word reads.
// - each set fault or warning injection bit forces its detector output; many at once.
// - fault hold clear drops faults after one response; set keeps them.
// - warning hold clear drops warnings after one response; set keeps them.
// - fault bits 14,12,11,10,9,8; all reset to zero.
// - warning bits 4,3,1,0.
// - writing zero clears every injection; reserved bits 13,6,5,2 do nothing.
// - only lockout and output overvoltage fault injections act while conversion is off.
// - all other injections act only while conversion is enabled.
module nvm_crc_and_fault_injection
   import nvmcf_pkg::*;
#(
   parameter int WORDS = 16,
   parameter int AW = 4
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic cmdValid,
   input wire logic cmdWrite,
   input wire logic [7:0] cmdCode,
   input wire logic [15:0] cmdWriteData,
   output logic cmdAccept,
   output logic [15:0] cmdReadData,
   input wire logic [WORDS*16-1:0] settingsImage,
   input wire logic settingsStoreDone,
   input wire logic settingsRestoreDone,
   input wire logic conversionEnabled,
   input wire logic faultResponse,
   input wire logic [15:0] detectorRaw,
   output logic [15:0] detectorOut,
   output logic crcBusy
);
   // refuse a word count the walk counter cannot reach
   if (WORDS < 1 || WORDS > (1 << AW))
   begin : g_bad_words
      $error("settings word count does not fit the address width");
   end

   ////////////////////////////////////////////////////////////////////////////
   // one word folded msb-first into the running crc
   function automatic logic [15:0] crcWord(input logic [15:0] crc, input logic [15:0] data);
      logic [15:0] c;
      c = crc;
      for (int i = 15; i >= 0; i--)
      begin
         if (c[15] ^ data[i])
            c = {c[14:0], 1'b0} ^ `NVMCF_CRC_POLY;
         else
            c = {c[14:0], 1'b0};
      end
      return c;
   endfunction : crcWord

   typedef struct packed {
      nvmcf_state_t phase;
      logic [AW:0] index;
      logic [15:0] crcAcc;
      logic [15:0] crc;
      logic [15:0] inject;
   } nvmcf_regs_t;

   nvmcf_regs_t r;
   nvmcf_regs_t next_r;
   logic [15:0] romData;
   logic [15:0] faultGate;
   logic [15:0] activeInject;
   logic writeCrc;
   logic writeInject;
   logic readCrc;
   logic readInject;
   logic [15:0] crcStep;

   // one crc step shared by the walk and its checker
   assign crcStep = crcWord(r.crcAcc, romData);

   ////////////////////////////////////////////////////////////////////////////
   nvmcf_settings_rom #(.WORDS(WORDS), .AW(AW)) settingsRom (
      .clk(clk),
      .reset(reset),
      .readAddr(r.index[AW-1:0]),
      .settingsImage(settingsImage),
      .readData(romData)
   );

   // command decode; a write to the checksum is not accepted
   assign writeCrc = cmdValid && cmdWrite && cmdCode == `NVMCF_CMD_CRC;
   assign writeInject = cmdValid && cmdWrite && cmdCode == `NVMCF_CMD_INJ;
   assign readCrc = cmdValid && !cmdWrite && cmdCode == `NVMCF_CMD_CRC;
   assign readInject = cmdValid && !cmdWrite && cmdCode == `NVMCF_CMD_INJ;
   assign cmdAccept = cmdValid && (cmdCode == `NVMCF_CMD_INJ
      || (cmdCode == `NVMCF_CMD_CRC && !cmdWrite));

   // register read data held in a flop, chosen on the request cycle
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         cmdReadData <= 16'h0000;
      else if (readCrc)
         cmdReadData <= r.crc;
      else if (readInject)
         cmdReadData <= r.inject;
   end

   ////////////////////////////////////////////////////////////////////////////
   // conversion gating: lockout and output overvoltage fault also act while stopped
   always_comb
   begin
      faultGate = conversionEnabled ? 16'hFFFF
         : (16'h0001 << `NVMCF_BIT_LOCKOUT) | (16'h0001 << `NVMCF_BIT_OVF);
      activeInject = r.inject & (`NVMCF_FAULT_MASK | `NVMCF_WARN_MASK) & faultGate;
      detectorOut = detectorRaw | activeInject;
   end
   assign crcBusy = r.phase != NVMCF_IDLE;

   ////////////////////////////////////////////////////////////////////////////
   // state update: crc walk and injection register
   always_comb
   begin
      next_r = r;
      case (r.phase)
         NVMCF_IDLE:
         begin
            if (settingsStoreDone || settingsRestoreDone)
            begin
               next_r.phase = NVMCF_REQ;
               next_r.index = '0;
            end
         end
         NVMCF_REQ:
         begin
            // address presented; rom answers next edge
            next_r.crcAcc = `NVMCF_CRC_SEED;
            next_r.phase = NVMCF_RUN;
            next_r.index = r.index + 1'b1;
         end
         NVMCF_RUN:
         begin
            next_r.crcAcc = crcStep;
            if (r.index == (AW+1)'(WORDS))
            begin
               next_r.crc = crcStep;
               next_r.phase = NVMCF_IDLE;
               next_r.index = '0;
            end
            else
               next_r.index = r.index + 1'b1;
         end
         default:
            next_r.phase = NVMCF_IDLE;
      endcase
      // non-persistent injections retire after one response
      if (faultResponse && !r.inject[`NVMCF_BIT_FAULT_HOLD])
         next_r.inject = next_r.inject & ~`NVMCF_FAULT_MASK;
      if (faultResponse && !r.inject[`NVMCF_BIT_WARN_HOLD])
         next_r.inject = next_r.inject & ~`NVMCF_WARN_MASK;
      // a host write wins over retirement in the same cycle
      if (writeInject)
         next_r.inject = cmdWriteData;
   end

   // boot begins in the request phase so a checksum exists after reset
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         r.phase <= NVMCF_REQ;
         r.index <= '0;
         r.crcAcc <= `NVMCF_CRC_SEED;
         r.crc <= 16'h0000;
         r.inject <= `NVMCF_INJ_RESET;
      end
      else
         r <= next_r;
   end

   ////////////////////////////////////////////////////////////////////////////
   // command port: what is taken, what is refused, what comes back
   chk_crc_write_refused: assert property (@(posedge clk) disable iff (reset)
      writeCrc |-> !cmdAccept) else $error("checksum write accepted");

   chk_inject_accepted: assert property (@(posedge clk) disable iff (reset)
      cmdValid && cmdCode == `NVMCF_CMD_INJ |-> cmdAccept) else $error("injection access refused");

   chk_unknown_refused: assert property (@(posedge clk) disable iff (reset)
      cmdValid && cmdCode != `NVMCF_CMD_INJ && cmdCode != `NVMCF_CMD_CRC |-> !cmdAccept)
      else $error("unknown command accepted");

   chk_crc_read_data: assert property (@(posedge clk) disable iff (reset)
      readCrc |=> cmdReadData == $past(r.crc)) else $error("checksum read wrong");

   chk_inject_read_data: assert property (@(posedge clk) disable iff (reset)
      readInject |=> cmdReadData == $past(r.inject)) else $error("injection read wrong");

   chk_read_data_holds: assert property (@(posedge clk) disable iff (reset)
      !readCrc && !readInject |=> $stable(cmdReadData)) else $error("read data moved");

   chk_write_stores_word: assert property (@(posedge clk) disable iff (reset)
      writeInject |=> r.inject == $past(cmdWriteData)) else $error("injection write lost");

   ////////////////////////////////////////////////////////////////////////////
   // detector forcing and conversion gating
   chk_inject_forces_out: assert property (@(posedge clk) disable iff (reset)
      (r.inject[`NVMCF_BIT_LOCKOUT]) |-> detectorOut[`NVMCF_BIT_LOCKOUT])
      else $error("lockout injection not forced");

   chk_overvolt_forced: assert property (@(posedge clk) disable iff (reset)
      r.inject[`NVMCF_BIT_OVF] |-> detectorOut[`NVMCF_BIT_OVF])
      else $error("overvoltage injection not forced");

   chk_running_forces: assert property (@(posedge clk) disable iff (reset)
      conversionEnabled |-> (r.inject & (`NVMCF_FAULT_MASK | `NVMCF_WARN_MASK) & ~detectorOut) == 16'h0000)
      else $error("injection not forced while running");

   chk_raw_passes: assert property (@(posedge clk) disable iff (reset)
      (detectorOut & detectorRaw) == detectorRaw) else $error("real detector masked");

   chk_reserved_no_effect: assert property (@(posedge clk) disable iff (reset)
      detectorOut[13] == detectorRaw[13] && detectorOut[2] == detectorRaw[2])
      else $error("reserved bit reached a detector");

   chk_stopped_gating: assert property (@(posedge clk) disable iff (reset)
      !conversionEnabled |-> detectorOut[14] == detectorRaw[14] && detectorOut[9] == detectorRaw[9])
      else $error("injection acted while stopped");

   ////////////////////////////////////////////////////////////////////////////
   // persistence: retirement only on a response, hold bits untouched by it
   chk_fault_retire_once: assert property (@(posedge clk) disable iff (reset)
      faultResponse && !r.inject[15] && !writeInject |=> (r.inject & `NVMCF_FAULT_MASK) == 16'h0000)
      else $error("fault injection not retired");

   chk_fault_hold_keeps: assert property (@(posedge clk) disable iff (reset)
      r.inject[15] && !writeInject |=> r.inject[14:8] == $past(r.inject[14:8]))
      else $error("held fault injection changed");

   chk_warn_retire_once: assert property (@(posedge clk) disable iff (reset)
      faultResponse && !r.inject[7] && !writeInject |=> (r.inject & `NVMCF_WARN_MASK) == 16'h0000)
      else $error("warning injection not retired");

   chk_warn_hold_keeps: assert property (@(posedge clk) disable iff (reset)
      r.inject[7] && !writeInject |=> r.inject[4:0] == $past(r.inject[4:0]))
      else $error("held warning injection changed");

   chk_inject_quiet: assert property (@(posedge clk) disable iff (reset)
      !faultResponse && !writeInject |=> $stable(r.inject)) else $error("injection changed unprompted");

   chk_hold_bits_kept: assert property (@(posedge clk) disable iff (reset)
      faultResponse && !writeInject |=> r.inject[15] == $past(r.inject[15]) && r.inject[7] == $past(r.inject[7]))
      else $error("hold bit lost on response");

   ////////////////////////////////////////////////////////////////////////////
   // checksum walk: start, seed, length and publication
   chk_crc_held_idle: assert property (@(posedge clk) disable iff (reset)
      r.phase == NVMCF_IDLE |=> $stable(r.crc)) else $error("checksum moved while idle");

   chk_store_starts: assert property (@(posedge clk) disable iff (reset)
      r.phase == NVMCF_IDLE && (settingsStoreDone || settingsRestoreDone) |=> r.phase == NVMCF_REQ)
      else $error("refresh not started");

   chk_request_seeds: assert property (@(posedge clk) disable iff (reset)
      r.phase == NVMCF_REQ |=> r.phase == NVMCF_RUN && r.crcAcc == `NVMCF_CRC_SEED)
      else $error("walk not seeded");

   chk_walk_ends: assert property (@(posedge clk) disable iff (reset)
      r.phase == NVMCF_RUN && r.index == (AW+1)'(WORDS) |=> r.phase == NVMCF_IDLE)
      else $error("walk overran");

   chk_crc_refresh_time: assert property (@(posedge clk) disable iff (reset)
      $rose(crcBusy) |-> ##[1:40] !crcBusy) else $error("checksum refresh too slow");

   chk_boot_crc_done: assert property (@(posedge clk) disable iff (reset)
      r.phase == NVMCF_RUN && r.index == (AW+1)'(WORDS) |=> r.crc == $past(crcStep))
      else $error("checksum not published");

   // main scenarios worth seeing once
   cov_crc_read: cover property (@(posedge clk) readCrc);
   cov_store_refresh: cover property (@(posedge clk) settingsStoreDone && !crcBusy);
   cov_retire: cover property (@(posedge clk) faultResponse && r.inject[14]);
   cov_multi_inject: cover property (@(posedge clk) detectorOut[12] && detectorOut[4] && !detectorRaw[12]);
   cov_stopped_lockout: cover property (@(posedge clk) !conversionEnabled && detectorOut[11] && !detectorRaw[11]);
endmodule : nvm_crc_and_fault_injection
`default_nettype wire

/* test/nvmcf_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
// host side of the command port, one word transfer per call
module nvmcf_host_model
(
   input wire logic clk,
   input wire logic cmdAccept,
   input wire logic [15:0] cmdReadData,
   output logic cmdValid,
   output logic cmdWrite,
   output logic [7:0] cmdCode,
   output logic [15:0] cmdWriteData
);
   initial
   begin
      cmdValid = 1'b0;
      cmdWrite = 1'b0;
      cmdCode = 8'h00;
      cmdWriteData = 16'h0000;
   end
   ////////////////////////////////////////////////////////////
   // request held to the taking edge; lines scrambled after, so stale values never count
   task automatic xfer(input logic w, input logic [7:0] code, input logic [15:0] wd,
                       output logic acc, output logic [15:0] rd);
      @(posedge clk);
      #1;
      cmdValid = 1'b1;
      cmdWrite = w;
      cmdCode = code;
      cmdWriteData = wd;
      @(posedge clk);
      acc = cmdAccept;
      #1;
      rd = cmdReadData;
      cmdValid = 1'b0;
      cmdCode = ~code;
      cmdWriteData = ~wd;
   endtask : xfer
endmodule : nvmcf_host_model
`default_nettype wire

/* test/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "nvmcf_consts.svh"
module tb_top;
   logic clk = 1'b0;
   logic reset, cmdValid, cmdWrite, cmdAccept, crcBusy, acc;
   logic settingsStoreDone, settingsRestoreDone, conversionEnabled, faultResponse;
   logic [7:0] cmdCode;
   logic [15:0] cmdWriteData, cmdReadData, detectorRaw, detectorOut, rd, ex;
   logic [31:0] settingsImage;
   int fails = 0;
   int check_count = 0;
   always #20 clk = ~clk;
   // two words keep the checksum walk short
   nvm_crc_and_fault_injection #(.WORDS(2), .AW(1)) uut (.clk(clk), .reset(reset), .cmdValid(cmdValid),
      .cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdWriteData(cmdWriteData), .cmdAccept(cmdAccept),
      .cmdReadData(cmdReadData), .settingsImage(settingsImage), .settingsStoreDone(settingsStoreDone),
      .settingsRestoreDone(settingsRestoreDone), .conversionEnabled(conversionEnabled),
      .faultResponse(faultResponse), .detectorRaw(detectorRaw), .detectorOut(detectorOut), .crcBusy(crcBusy));
   nvmcf_host_model host (.clk(clk), .cmdAccept(cmdAccept), .cmdReadData(cmdReadData), .cmdValid(cmdValid),
      .cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdWriteData(cmdWriteData));
   ////////////////////////////////////////////////////////////
   function automatic logic [15:0] crcOf(input logic [31:0] img);
      logic [15:0] c;
      c = `NVMCF_CRC_SEED;
      for (int i = 0; i < 32; i++)
      begin
         c = (c[15] ^ img[{i[4] ? 5'd16 : 5'd0} + 5'(15 - i[3:0])]) ? ((c << 1) ^ `NVMCF_CRC_POLY) : (c << 1);
      end
      return c;
   endfunction : crcOf
   task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e)
      begin
         fails++;
         $display("wrong value %s expected %h seen %h", name, e, g);
      end
   endtask : chk
   // bounded wait for the checksum walk to finish
   task automatic waitIdle();
      int n;
      n = 0;
      @(posedge clk);
      #1;
      while (crcBusy !== 1'b0 && n < 200)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      chk("crc busy", 16'h0000, {15'h0000, crcBusy});
   endtask : waitIdle
   task automatic crcRead(input string name);
      host.xfer(1'b0, `NVMCF_CMD_CRC, 16'h0000, acc, rd);
      chk("crc accept", 16'h0001, {15'h0000, acc});
      chk(name, crcOf(settingsImage), rd);
   endtask : crcRead
   task automatic inj(input logic [15:0] wd);
      host.xfer(1'b1, `NVMCF_CMD_INJ, wd, acc, rd);
   endtask : inj
   task automatic respond(input logic [15:0] eReg, input logic [15:0] eDet);
      faultResponse = 1'b1;
      @(posedge clk);
      #1;
      faultResponse = 1'b0;
      chk("detector after response", eDet, detectorOut);
      host.xfer(1'b0, `NVMCF_CMD_INJ, 16'h0000, acc, rd);
      chk("injection after response", eReg, rd);
   endtask : respond
   task automatic summarize();
      $display("checks %0d errors %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : summarize
   ////////////////////////////////////////////////////////////
   initial
   begin
      #100us;
      fails++;
      summarize();
   end
   initial
   begin
      {reset, settingsStoreDone, settingsRestoreDone, faultResponse} = 4'hF;
      {settingsStoreDone, settingsRestoreDone, faultResponse} = 3'h0;
      conversionEnabled = 1'b1;
      detectorRaw = 16'h0000;
      settingsImage = 32'h1234ABCD;
      repeat (4) @(posedge clk);
      #1;
      reset = 1'b0;
      waitIdle();
      crcRead("crc at boot");
      host.xfer(1'b0, `NVMCF_CMD_INJ, 16'h0000, acc, rd);
      chk("injection reset", `NVMCF_INJ_RESET, rd);
      host.xfer(1'b1, `NVMCF_CMD_CRC, 16'h5555, acc, rd);
      chk("crc write refused", 16'h0000, {15'h0000, acc});
      crcRead("crc after refused write");
      settingsImage = 32'h0F0F5AA5;
      settingsStoreDone = 1'b1;
      @(posedge clk);
      #1;
      settingsStoreDone = 1'b0;
      waitIdle();
      crcRead("crc after store");
      settingsImage = 32'hFFFF0001;
      settingsRestoreDone = 1'b1;
      @(posedge clk);
      #1;
      settingsRestoreDone = 1'b0;
      waitIdle();
      crcRead("crc after restore");
      // bits 0 to 14 each alone with both hold bits set, conversion off then on; reserved bits must stay silent
      for (int b = 0; b < 15; b++)
      begin
         for (int c = 0; c < 2; c++)
         begin
            conversionEnabled = c[0];
            inj(`NVMCF_HOLD_MASK | (16'h0001 << b));
            ex = c[0] ? (`NVMCF_FAULT_MASK | `NVMCF_WARN_MASK) : 16'h0900;
            chk("single injection", ex & (16'h0001 << b), detectorOut);
         end
      end
      detectorRaw = 16'h2000;
      inj(16'hFFFF);
      chk("all injections with raw", 16'h7F1B, detectorOut);
      host.xfer(1'b0, `NVMCF_CMD_INJ, 16'h0000, acc, rd);
      chk("injection readback", 16'hFFFF, rd);
      detectorRaw = 16'h0000;
      inj(16'h5F1B);
      respond(16'h0000, 16'h0000);
      inj(16'hDF1B);
      respond(16'hDF00, 16'h5F00);
      inj(16'h5F9B);
      respond(16'h009B, 16'h001B);
      summarize();
   end
endmodule : tb_top
`default_nettype wire
